// file: design/sld_pkg.sv
package sld_pkg;

  // Sizes of the display store and the panel
  localparam int MEM_BYTES = 40;
  localparam int MEM_BYTES_FOUR = 22;
  localparam int NUM_COMMONS = 8;
  localparam int NUM_SEGMENTS = 44;
  localparam int SLOT_CYCLES_DEF = 64;

  // Register map, byte addresses
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] MEM_BASE = 12'h100;

  // Control word field positions
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_TRUN_BIT = 6;
  localparam int CTRL_FLAG_BIT = 8;
  localparam int CTRL_IEN_BIT = 9;
  localparam int CTRL_BIAS8_BIT = 12;

  // Status word field positions
  localparam int STAT_COM_LSB = 0;
  localparam int STAT_POL_BIT = 3;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_DIV_BIT = 5;
  localparam int STAT_BIAS_LSB = 6;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic TRUN_RST = 1'b0;
  localparam logic BIAS8_RST = 1'b1;
  localparam logic IEN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Display mode codes; any code with the top bit set is eight-common
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_DUTY2 = 3'h1;
  localparam logic [2:0] MODE_DUTY3 = 3'h2;
  localparam logic [2:0] MODE_DUTY4 = 3'h3;
  localparam logic [2:0] MODE_DUTY8 = 3'h4;

  typedef enum logic [2:0] {
    SYS_RUN = 3'h0,
    SYS_SLEEP = 3'h1,
    SYS_TIMER = 3'h2,
    SYS_RTC = 3'h3,
    SYS_STOP = 3'h4,
    SYS_DS_RTC = 3'h5,
    SYS_DS_STOP = 3'h6
  } sld_sysmode_t;

  typedef enum logic [1:0] {
    BIAS_NONE = 2'h0,
    BIAS_HALF = 2'h1,
    BIAS_THIRD = 2'h2,
    BIAS_QUARTER = 2'h3
  } sld_bias_t;

  typedef struct packed {
    logic [NUM_COMMONS-1:0] commonSelect;
    logic [NUM_COMMONS-1:0] commonUsed;
    logic [NUM_SEGMENTS-1:0] segmentSelect;
    logic framePolarity;
    sld_bias_t bias;
    logic dividerOn;
  } sld_drive_t;

endpackage

// file: design/sld_display_mem.sv
`timescale 1ns/1ps
module sld_display_mem #(
  parameter int DEPTH = 40,
  parameter int WIDTH = 8,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic writeEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [AW-1:0] busAddr,
  output logic [WIDTH-1:0] busData,
  input wire logic [AW-1:0] scanAddr,
  output logic [WIDTH-1:0] scanData
);

  logic [WIDTH-1:0] store [DEPTH];

  // Two independent read ports so the scan never waits on software
  always_ff @(posedge clk) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
    busData <= store[busAddr];
    scanData <= store[scanAddr];
  end

endmodule

// file: design/sld_timing.sv
`timescale 1ns/1ps
module sld_timing #(
  parameter int SLOT_CYCLES = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] lastCom,
  output logic slotStart,
  output logic [2:0] comIdx,
  output logic evenFrame,
  output logic cycleDone
);

  localparam int CW = $clog2(SLOT_CYCLES);
  localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYCLES - 1);

  typedef enum logic [1:0] {
    TG_IDLE = 2'b00,
    TG_ODD = 2'b01,
    TG_EVEN = 2'b11
  } sld_tg_state_t;

  sld_tg_state_t state_reg, state_next;
  logic [CW-1:0] slot_reg;
  logic [2:0] com_reg;

  wire slotEnd = (slot_reg == SLOT_LAST);
  wire frameEnd = slotEnd && (com_reg == lastCom);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TG_IDLE: state_next = TG_ODD;
      TG_ODD: if (frameEnd) state_next = TG_EVEN;
      TG_EVEN: if (frameEnd) state_next = TG_ODD;
      default: state_next = TG_IDLE;
    endcase
    if (!run) begin
      state_next = TG_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= TG_IDLE;
      slot_reg <= '0;
      com_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      slot_reg <= (state_reg == TG_IDLE || slotEnd) ? '0 : slot_reg + 1'b1;
      if (state_reg == TG_IDLE || frameEnd) begin
        com_reg <= 3'h0;
      end else if (slotEnd) begin
        com_reg <= com_reg + 3'h1;
      end
    end
  end

  assign comIdx = com_reg;
  assign evenFrame = (state_reg == TG_EVEN);
  assign slotStart = run && (slot_reg == '0) && (state_reg != TG_IDLE);
  assign cycleDone = run && frameEnd && (state_reg == TG_EVEN);

endmodule

// file: design/sld_drive_sequencer.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// How it works
// - Codes 001, 010, 011: four commons at 1/2, 1/3, 1/4 duty; bias fixed.
// - Code 100 gives eight commons; bias bit picks 1/3 or 1/4 bias.
// - Scan runs in run and sleep states, and in timer state only if the timer-run bit is set; halts in all others.
// - In timer state with the timer-run bit set the display keeps going; no interrupt leaves in timer state.
// - Drive is an AC pattern of two consecutive frames.
// - Eight-common mode scans all commons 0 to 7.
// - At 1/2 duty only commons 0 and 1 scan.
// - At 1/3 duty commons 0 to 2 scan, common 3 idle.
// - Every finished drive cycle sets the flag, enable or not.
// - Flag and enable both set raise the interrupt request.
// - Writing 0 to the flag clears it; handlers must do so.
// - Store holds 40 bytes; four-common mode uses the first 22.
// - Each common slot fetches the store and updates segments with it.
// - A 1 bit selects its segment in that slot, 0 leaves it unselected.
// - Software access to the store never stalls nor disturbs the scan.
// - Every byte stays plain read/write storage.
// - Eight-common: byte k drives segment k, bit j for common j.
// - Four-common: byte k low nibble segment 2k, high nibble 2k+1.
// - Nibble bits beyond the active commons are ignored.
// - Code 000 halts drive and turns the divider path off.
// - Second frame is the polarity-inverted first frame.
module sld_drive_sequencer
  import sld_pkg::*;
#(
  parameter int SLOT_CYCLES = sld_pkg::SLOT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sld_pkg::sld_sysmode_t sysMode,
  output sld_pkg::sld_drive_t panelDrive,
  output logic cycleIrq
);

  // Codes above 100 fall to the default and decode as eight-common
  function automatic logic [2:0] lastCommon(input logic [2:0] mode);
    unique case (mode)
      MODE_OFF: return 3'h0;
      MODE_DUTY2: return 3'h1;
      MODE_DUTY3: return 3'h2;
      MODE_DUTY4: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] usedCommons(input logic [2:0] mode);
    unique case (mode)
      MODE_OFF: return 8'h00;
      MODE_DUTY2: return 8'h03;
      MODE_DUTY3: return 8'h07;
      MODE_DUTY4: return 8'h0F;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic sld_bias_t biasFor(input logic [2:0] mode,
                                        input logic bias8);
    unique case (mode)
      MODE_OFF: return BIAS_NONE;
      MODE_DUTY2: return BIAS_HALF;
      MODE_DUTY3: return BIAS_THIRD;
      MODE_DUTY4: return BIAS_THIRD;
      default: return bias8 ? BIAS_QUARTER : BIAS_THIRD;
    endcase
  endfunction

  function automatic logic [6:0] memSlot(input logic [11:0] a);
    logic [11:0] off;
    off = a - MEM_BASE;
    return {(a >= MEM_BASE) && (off[11:2] < 10'(MEM_BYTES))
            && (off[1:0] == 2'b00), off[7:2]};
  endfunction

  function automatic logic [NUM_SEGMENTS-1:0] placeByte(
    input logic [NUM_SEGMENTS-1:0] acc,
    input logic [5:0] idx,
    input logic [7:0] d,
    input logic [2:0] com,
    input logic eight
  );
    logic [NUM_SEGMENTS-1:0] r;
    r = acc;
    if (eight) begin
      r[idx] = d[com];
    end else begin
      r[{idx[4:0], 1'b0}] = d[{1'b0, com[1:0]}];
      r[{idx[4:0], 1'b1}] = d[{1'b1, com[1:0]}];
    end
    return r;
  endfunction

  // Software-visible control state
  logic [2:0] mode_reg;
  logic timerRun_reg;
  logic bias8_reg;
  logic irqEn_reg;
  logic irqFlag_reg, irqFlag_next;
  logic cycleIrq_reg, cycleIrq_next;
  logic [31:0] regRead_reg, regRead_next;
  logic memRead_reg;

  // Scan pipeline state
  logic sweepBusy_reg;
  logic [5:0] sweepIdx_reg;
  logic rdValid_reg;
  logic rdLast_reg;
  logic [5:0] rdIdx_reg;
  logic [2:0] comLatch_reg;
  logic polLatch_reg;
  logic [NUM_SEGMENTS-1:0] segAcc_reg, segAcc_next;
  sld_drive_t drive_reg, drive_next;

  // Bus decode
  wire setupPhase = psel && !penable;
  wire accessPhase = psel && penable;
  wire [6:0] memHit = memSlot(paddr);
  wire isCtrl = (paddr == CTRL_OFF);
  wire isStat = (paddr == STAT_OFF);
  wire isMem = memHit[6];
  wire mapped = isCtrl || isStat || isMem;
  wire ctrlWrite = accessPhase && pwrite && isCtrl;
  wire memWrite = accessPhase && pwrite && isMem;
  wire [2:0] newMode = pwdata[CTRL_MODE_LSB +: 3];
  wire flagClear = ctrlWrite && !pwdata[CTRL_FLAG_BIT];
  wire modeChange = ctrlWrite && (newMode != mode_reg);

  // Power state and mode qualification
  wire inTimer = (sysMode == SYS_TIMER);
  wire powerOk = (sysMode == SYS_RUN) || (sysMode == SYS_SLEEP)
                 || (inTimer && timerRun_reg);
  wire displayOn = (mode_reg != MODE_OFF);
  wire running = displayOn && powerOk;
  wire eightMode = mode_reg[2];
  // A mode write drops run for one cycle so the scan restarts at common 0
  wire scanRun = running && !modeChange;
  wire [2:0] lastCom = lastCommon(mode_reg);
  wire [5:0] lastByte = eightMode ? 6'(MEM_BYTES - 1)
                                  : 6'(MEM_BYTES_FOUR - 1);

  wire slotStart;
  wire [2:0] comIdx;
  wire evenFrame;
  wire cycleDone;
  wire [7:0] busByte;
  wire [7:0] scanByte;

  sld_timing #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_timing (
    .clk(clk),
    .reset(reset),
    .run(scanRun),
    .lastCom(lastCom),
    .slotStart(slotStart),
    .comIdx(comIdx),
    .evenFrame(evenFrame),
    .cycleDone(cycleDone)
  );

  // Separate scan port keeps bus traffic off the display path
  sld_display_mem #(
    .DEPTH(MEM_BYTES),
    .WIDTH(8),
    .AW(6)
  ) u_mem (
    .clk(clk),
    .writeEn(memWrite),
    .writeAddr(memHit[5:0]),
    .writeData(pwdata[7:0]),
    .busAddr(memHit[5:0]),
    .busData(busByte),
    .scanAddr(sweepIdx_reg),
    .scanData(scanByte)
  );

  // Zero wait states: the dual-port store never makes the bus wait
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;
  assign prdata = memRead_reg ? {24'h00_0000, busByte} : regRead_reg;

  // Set wins over a clear landing in the same cycle
  always_comb begin
    irqFlag_next = irqFlag_reg;
    if (flagClear) begin
      irqFlag_next = 1'b0;
    end
    if (cycleDone) begin
      irqFlag_next = 1'b1;
    end
  end

  // Flag still records cycles in timer state; only the request is held
  assign cycleIrq_next = irqFlag_next && irqEn_reg
                         && !inTimer;

  // Word captured in setup, so the access cycle reads a flop
  always_comb begin
    regRead_next = RDATA_RST;
    if (setupPhase && isCtrl) begin
      regRead_next[CTRL_MODE_LSB +: 3] = mode_reg;
      regRead_next[CTRL_TRUN_BIT] = timerRun_reg;
      regRead_next[CTRL_FLAG_BIT] = irqFlag_reg;
      regRead_next[CTRL_IEN_BIT] = irqEn_reg;
      regRead_next[CTRL_BIAS8_BIT] = bias8_reg;
    end else if (setupPhase && isStat) begin
      regRead_next[STAT_COM_LSB +: 3] = drive_reg.commonSelect == 8'h00
                                        ? 3'h0 : comLatch_reg;
      regRead_next[STAT_POL_BIT] = drive_reg.framePolarity;
      regRead_next[STAT_RUN_BIT] = running;
      regRead_next[STAT_DIV_BIT] = drive_reg.dividerOn;
      regRead_next[STAT_BIAS_LSB +: 2] = drive_reg.bias;
    end else if (accessPhase) begin
      regRead_next = regRead_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_RST;
      timerRun_reg <= TRUN_RST;
      bias8_reg <= BIAS8_RST;
      irqEn_reg <= IEN_RST;
    end else if (ctrlWrite) begin
      mode_reg <= newMode;
      timerRun_reg <= pwdata[CTRL_TRUN_BIT];
      bias8_reg <= pwdata[CTRL_BIAS8_BIT];
      irqEn_reg <= pwdata[CTRL_IEN_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqFlag_reg <= FLAG_RST;
      cycleIrq_reg <= 1'b0;
      regRead_reg <= RDATA_RST;
      memRead_reg <= 1'b0;
    end else begin
      irqFlag_reg <= irqFlag_next;
      cycleIrq_reg <= cycleIrq_next;
      regRead_reg <= regRead_next;
      memRead_reg <= psel && !pwrite && isMem;
    end
  end

  assign cycleIrq = cycleIrq_reg;

  // Fetch sweep: every slot reads all live bytes, one per cycle
  wire sweepEnd = sweepBusy_reg && (sweepIdx_reg == lastByte);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sweepBusy_reg <= 1'b0;
      sweepIdx_reg <= 6'h00;
      comLatch_reg <= 3'h0;
      polLatch_reg <= 1'b0;
    end else if (!scanRun) begin
      sweepBusy_reg <= 1'b0;
      sweepIdx_reg <= 6'h00;
    end else if (slotStart) begin
      sweepBusy_reg <= 1'b1;
      sweepIdx_reg <= 6'h00;
      comLatch_reg <= comIdx;
      polLatch_reg <= evenFrame;
    end else if (sweepBusy_reg) begin
      sweepBusy_reg <= !sweepEnd;
      sweepIdx_reg <= sweepEnd ? 6'h00 : sweepIdx_reg + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdValid_reg <= 1'b0;
      rdLast_reg <= 1'b0;
      rdIdx_reg <= 6'h00;
    end else begin
      rdValid_reg <= scanRun && sweepBusy_reg;
      rdLast_reg <= scanRun && sweepEnd;
      rdIdx_reg <= sweepIdx_reg;
    end
  end

  // Only the bit for the latched common is picked, so unused bits are inert
  always_comb begin
    segAcc_next = segAcc_reg;
    if (slotStart) begin
      segAcc_next = '0;
    end else if (rdValid_reg) begin
      segAcc_next = placeByte(segAcc_reg, rdIdx_reg, scanByte,
                              comLatch_reg,
                              eightMode);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      segAcc_reg <= '0;
    end else begin
      segAcc_reg <= segAcc_next;
    end
  end

  // Common and segments change together once the sweep has finished
  always_comb begin
    drive_next = drive_reg;
    drive_next.bias = biasFor(mode_reg, bias8_reg);
    drive_next.dividerOn = displayOn;
    drive_next.commonUsed = usedCommons(mode_reg);
    // Stale common of the old mode must not outlive a mode write
    if (!running || modeChange) begin
      drive_next.commonSelect = 8'h00;
      drive_next.segmentSelect = '0;
      drive_next.framePolarity = 1'b0;
    end else if (rdLast_reg) begin
      drive_next.commonSelect = 8'h01 << comLatch_reg;
      drive_next.segmentSelect = segAcc_next;
      drive_next.framePolarity = polLatch_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign panelDrive = drive_reg;

endmodule

// file: sim/sld_drive_sequencer_sva.sv
`timescale 1ns/1ps
module sld_drive_sequencer_sva
  import sld_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sld_pkg::sld_sysmode_t sysMode,
  input wire sld_pkg::sld_drive_t panelDrive,
  input wire logic cycleIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [7:0] sel = panelDrive.commonSelect;
  wire logic [7:0] used = panelDrive.commonUsed;
  // Top active common of a contiguous mask
  wire logic [7:0] top = used & ~(used >> 1);
  wire logic acc = psel && penable;
  wire logic mapped = paddr == CTRL_OFF || paddr == STAT_OFF ||
    (paddr >= MEM_BASE && paddr < 12'h1a0 && paddr[1:0] == 2'h0);
  wire logic halt = sysMode inside {SYS_RTC, SYS_STOP, SYS_DS_RTC,
    SYS_DS_STOP};

  a_slave_error: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_used_only: assert property ((sel & ~used) == 8'h00)
    else $error("unused common selected");
  // Restart on a code change is excused by the zero common that a mode write forces first
  a_com_ascend: assert property ($changed(sel) && sel != 8'h00 &&
    $past(sel) != 8'h00 && $stable(used) |-> sel == ($past(sel) << 1) ||
    (sel == 8'h01 && $past(sel) == top))
    else $error("common order broken");
  a_pol_wrap: assert property ($changed(sel) && sel == 8'h01 &&
    $past(sel) != 8'h00 |-> $changed(panelDrive.framePolarity))
    else $error("polarity kept across frames");
  a_pol_hold: assert property ($changed(panelDrive.framePolarity) &&
    sel != 8'h00 && $past(sel) != 8'h00 |-> sel == 8'h01)
    else $error("polarity changed inside frame");
  a_bias_half: assert property (used == 8'h03 |->
    panelDrive.bias == BIAS_HALF) else $error("bias wrong at half duty");
  a_bias_eight: assert property (used == 8'hff |->
    panelDrive.bias inside {BIAS_THIRD, BIAS_QUARTER})
    else $error("bias wrong in eight common mode");
  a_div_off: assert property (!panelDrive.dividerOn |->
    used == 8'h00 && sel == 8'h00 && panelDrive.bias == BIAS_NONE)
    else $error("drive active with divider off");
  a_seg_spare: assert property (used == 8'hff |->
    panelDrive.segmentSelect[43:40] == 4'h0)
    else $error("spare segments driven");
  a_halt_clear: assert property (halt [*2] |=> sel == 8'h00)
    else $error("scan runs in halted state");
  a_timer_quiet: assert property (sysMode == SYS_TIMER |=>
    !cycleIrq) else $error("interrupt raised in timer state");
  a_flag_clear: assert property (acc && pwrite &&
    paddr == CTRL_OFF && !pwdata[CTRL_FLAG_BIT] |-> ##2 !cycleIrq)
    else $error("interrupt stays after flag clear");

  c_irq: cover property ($rose(cycleIrq));
  c_eight: cover property (used == 8'hff && sel == 8'h80);
  c_err: cover property (acc && pslverr);
endmodule

bind sld_drive_sequencer sld_drive_sequencer_sva chk_u (.clk(clk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sysMode(sysMode), .panelDrive(panelDrive),
  .cycleIrq(cycleIrq));

// file: sim/sld_panel_model.sv
`timescale 1ns/1ps
// Passive panel: reports each new common slot it is driven with
module sld_panel_model
  import sld_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire sld_pkg::sld_drive_t drive,
  output logic seenValid,
  output sld_pkg::sld_drive_t seen
);
  logic [7:0] prevSel_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prevSel_reg <= 8'h00;
      seenValid <= 1'b0;
      seen <= '0;
    end else begin
      prevSel_reg <= drive.commonSelect;
      seenValid <= drive.commonSelect != prevSel_reg &&
        drive.commonSelect != 8'h00;
      seen <= drive;
    end
  end
endmodule

// file: sim/tb_segment_lcd_drive_sequencer.sv
`timescale 1ns/1ps
module tb_segment_lcd_drive_sequencer;
  import sld_pkg::*;
  localparam int S = 48;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sld_sysmode_t sysMode = SYS_RUN;
  sld_drive_t panelDrive;
  logic cycleIrq;
  logic seenValid;
  sld_drive_t seen;
  sld_drive_t expQ[$];
  logic [32:0] rdQ[$];
  logic [7:0] mem[40];
  logic [31:0] rnd = 32'h5a22_1c62;
  int num_errors = 0;
  int compares = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  sld_drive_sequencer #(.SLOT_CYCLES(S)) dut_u (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysMode(sysMode), .panelDrive(panelDrive), .cycleIrq(cycleIrq));
  sld_panel_model panel_u (.clk(clk), .reset(reset), .drive(panelDrive),
    .seenValid(seenValid), .seen(seen));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] ctrl(input logic [2:0] m,
    input logic tr, input logic fl, input logic ie, input logic b8);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CTRL_MODE_LSB +: 3] = m;
    v[CTRL_TRUN_BIT] = tr;
    v[CTRL_FLAG_BIT] = fl;
    v[CTRL_IEN_BIT] = ie;
    v[CTRL_BIAS8_BIT] = b8;
    return v;
  endfunction

  function automatic sld_drive_t exp_drive(input logic [2:0] m,
    input logic b8, input int c, input logic p);
    sld_drive_t d;
    d = '0;
    d.commonSelect = 8'h01 << c;
    d.commonUsed = m[2] ? 8'hff : 8'h0f >> (3 - m);
    d.framePolarity = p;
    d.dividerOn = 1'b1;
    d.bias = m == 3'h1 ? BIAS_HALF : (m[2] && b8) ? BIAS_QUARTER : BIAS_THIRD;
    for (int k = 0; k < 44; k++) begin
      if (m[2]) begin
        d.segmentSelect[k] = k < 40 ? mem[k][c] : 1'b0;
      end else begin
        d.segmentSelect[k] = mem[k / 2][4 * (k % 2) + c];
      end
    end
    return d;
  endfunction

  task automatic check_drive(input sld_drive_t e, input sld_drive_t g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR panelDrive exp %h got %h", e, g);
    end
  endtask

  task automatic check_word(input string n, input logic [32:0] e,
    input logic [32:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("Compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, rnd);
  endtask

  task automatic wait_irq(input logic v, input int n);
    for (int t = 0; t < n && cycleIrq !== v; t++) @(posedge clk);
    check_word("cycleIrq", {32'h0, v}, {32'h0, cycleIrq});
  endtask

  // Flag bit written 1 on plain writes so no clear is issued by accident
  task automatic run_mode(input logic [2:0] m, input logic b8);
    int last;
    last = m[2] ? 7 : m;
    apb(1'b1, CTRL_OFF, ctrl(3'h0, 1'b0, 1'b1, 1'b0, b8));
    repeat (4) @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c <= last; c++) begin
        expQ.push_back(exp_drive(m, b8, c, p[0]));
      end
    end
    apb(1'b1, CTRL_OFF, ctrl(m, 1'b0, 1'b1, 1'b0, b8));
    rd(MEM_BASE + 12'h09c, {25'h000_0000, mem[39]});
    for (int t = 0; t < 20 * S && expQ.size() > 0; t++) @(posedge clk);
    check_word("expQ left", 33'h0, 33'(expQ.size()));
    expQ.delete();
  endtask

  always @(posedge clk) begin
    if (psel && penable) begin
      check_word("pready", 33'h1, {32'h0, pready});
    end
    if (psel && penable && !pwrite && rdQ.size() > 0) begin
      check_word("prdata", rdQ.pop_front(), {pslverr, prdata});
    end
    if (seenValid && expQ.size() > 0) begin
      check_drive(expQ.pop_front(), seen);
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(CTRL_OFF, {1'b0, 32'h0000_1000});
    rd(12'h1a0, 33'h1_0000_0000);
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      mem[k] = rnd[7:0];
      apb(1'b1, MEM_BASE + 12'(4 * k), rnd);
    end
    for (int k = 0; k < 40; k++) begin
      rd(MEM_BASE + 12'(4 * k), {25'h000_0000, mem[k]});
    end
    for (int i = 0; i < 6; i++) begin
      run_mode(i < 4 ? 3'(i + 1) : (i == 4 ? 3'h4 : 3'h7), i == 4);
    end
    apb(1'b1, CTRL_OFF, ctrl(3'h3, 1'b0, 1'b1, 1'b1, 1'b1));
    wait_irq(1'b1, 10 * S);
    apb(1'b1, CTRL_OFF, ctrl(3'h3, 1'b0, 1'b0, 1'b1, 1'b1));
    repeat (2) @(posedge clk);
    check_word("cycleIrq", 33'h0, {32'h0, cycleIrq});
    wait_irq(1'b1, 8 * S + 4);
    // Single clock here; the slow source is chosen outside this block
    apb(1'b1, CTRL_OFF, ctrl(3'h3, 1'b1, 1'b0, 1'b1, 1'b1));
    sysMode <= SYS_TIMER;
    repeat (9 * S) @(posedge clk);
    check_word("cycleIrq", 33'h0, {32'h0, cycleIrq});
    rd(CTRL_OFF, {1'b0, ctrl(3'h3, 1'b1, 1'b1, 1'b1, 1'b1)});
    // Sleep keeps the scan and lets the held request out
    sysMode <= SYS_SLEEP;
    wait_irq(1'b1, 4);
    @(posedge clk);
    sysMode <= SYS_RTC;
    repeat (4) @(posedge clk);
    check_word("commonSelect", 33'h0,
      {25'h0, panelDrive.commonSelect});
    sysMode <= SYS_RUN;
    apb(1'b1, CTRL_OFF,
      ctrl(3'h0, 1'b0, 1'b0, 1'b1, 1'b1));
    sysMode <= SYS_DS_STOP;
    repeat (4) @(posedge clk);
    check_drive('0, panelDrive);
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog exp done got timeout");
    end_sim;
  end
endmodule
